//--- rtl/ocf_regs.vh
// How it works
// - any mode sets fault status, notifies host
// - mode 00 limits current forever
// - mode 01 limits until voltage floor breached
// - mode 10 limits for delay, then retries
// - mode 11 shuts down immediately, then retries
// - retry 001 gives one restart attempt
// - retry 010 gives two restart attempts
// - retry 111 restarts without limit
// - attempts exhausted means latched off
// - attempt spacing is delay count times unit
// - delay code decodes, top code 128 units
// - unit length from time-unit register
// - continuous retry stops on off or fault
`ifndef OCF_REGS_VH
`define OCF_REGS_VH
`define OCF_RESP_MSB 7
`define OCF_RESP_LSB 6
`define OCF_RETRY_MSB 5
`define OCF_RETRY_LSB 3
`define OCF_DLY_MSB 2
`define OCF_DLY_LSB 0
`define OCF_CFG_RESET 8'hC0
`define OCF_UNIT_RESET 16'h0001
`define OCF_RESP_IGNORE 2'h0
`define OCF_RESP_COND 2'h1
`define OCF_RESP_DELAY 2'h2
`define OCF_RESP_OFF 2'h3
`define OCF_RETRY_NONE 3'h0
`define OCF_RETRY_CONT 3'h7
`define OCF_RESTART_TIME 16'h0040
`endif

//--- rtl/ocf_core.v
`timescale 1ns/100ps
`default_nettype none
`include "ocf_regs.vh"

module ocf_core (
  input wire clk,
  input wire rst_b,
  input wire cfg_we,
  input wire [7:0] cfg_wdata,
  input wire unit_we,
  input wire [15:0] unit_wdata,
  input wire oc_detect,
  input wire vout_below_floor,
  input wire output_on_cmd,
  input wire other_fault,
  input wire fault_clear,
  input wire restart_ok,
  output reg [7:0] cfg_rdata,
  output reg [15:0] unit_rdata,
  output reg oc_status,
  output reg host_alert_b,
  output reg output_enable,
  output reg current_limit,
  output reg latched_off,
  output reg [2:0] attempts_used
);

  localparam ST_RUN = 3'h0;
  localparam ST_LIMIT = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_TRY = 3'h3;
  localparam ST_LATCH = 3'h4;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [15:0] unit_cnt;
  reg [7:0] unit_num;
  reg [15:0] try_cnt;
  reg [7:0] dly_units;
  reg prev_on;
  wire [1:0] resp;
  wire [2:0] retry;
  wire unit_tick;
  wire delay_done;
  wire can_retry;
  wire turned_on;

  assign resp = cfg_rdata[`OCF_RESP_MSB:`OCF_RESP_LSB];
  assign retry = cfg_rdata[`OCF_RETRY_MSB:`OCF_RETRY_LSB];
  assign unit_tick = (unit_cnt >= unit_rdata);
  assign delay_done = unit_tick && (unit_num + 8'h01 >= dly_units);
  assign can_retry = (retry == `OCF_RETRY_CONT) || (attempts_used < retry);
  assign turned_on = output_on_cmd && !prev_on;

  always @* begin
    case (cfg_rdata[`OCF_DLY_MSB:`OCF_DLY_LSB])
      3'h0: dly_units = 8'h01;
      3'h1: dly_units = 8'h01;
      3'h2: dly_units = 8'h02;
      3'h3: dly_units = 8'h08;
      3'h4: dly_units = 8'h10;
      3'h5: dly_units = 8'h20;
      3'h6: dly_units = 8'h40;
      default: dly_units = 8'h80;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (oc_detect) begin
          if (resp == `OCF_RESP_OFF)
            next_state = can_retry ? ST_WAIT : ST_LATCH;
          // already below floor, no limiting phase
          else if (resp == `OCF_RESP_COND && vout_below_floor)
            next_state = can_retry ? ST_WAIT : ST_LATCH;
          else
            next_state = ST_LIMIT;
        end
      end
      ST_LIMIT: begin
        if (!oc_detect)
          next_state = ST_RUN;
        else if (resp == `OCF_RESP_COND && vout_below_floor)
          next_state = can_retry ? ST_WAIT : ST_LATCH;
        else if (resp == `OCF_RESP_DELAY && delay_done)
          next_state = can_retry ? ST_WAIT : ST_LATCH;
        else if (resp == `OCF_RESP_OFF)
          next_state = can_retry ? ST_WAIT : ST_LATCH;
      end
      ST_WAIT: begin
        if (delay_done)
          next_state = ST_TRY;
      end
      ST_TRY: begin
        if (oc_detect)
          next_state = can_retry ? ST_WAIT : ST_LATCH;
        else if (restart_ok || try_cnt >= `OCF_RESTART_TIME)
          next_state = ST_RUN;
      end
      ST_LATCH: begin
        if (fault_clear || turned_on)
          next_state = ST_RUN;
      end
      default: next_state = ST_RUN;
    endcase
    // off or other fault ends retrying
    if (state != ST_LATCH && (!output_on_cmd || other_fault))
      next_state = ST_LATCH;
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (!rst_b) begin
      state <= ST_RUN;
      cfg_rdata <= `OCF_CFG_RESET;
      unit_rdata <= `OCF_UNIT_RESET;
      unit_cnt <= 16'h0000;
      unit_num <= 8'h00;
      try_cnt <= 16'h0000;
      attempts_used <= 3'h0;
      prev_on <= 1'b0;
      oc_status <= 1'b0;
      host_alert_b <= 1'b1;
      output_enable <= 1'b0;
      current_limit <= 1'b0;
      latched_off <= 1'b0;
    end else begin
      state <= next_state;
      prev_on <= output_on_cmd;
      if (cfg_we)
        cfg_rdata <= cfg_wdata;
      if (unit_we)
        unit_rdata <= unit_wdata;
      // timers restart on every state change
      if (next_state != state || unit_tick)
        unit_cnt <= 16'h0000;
      else
        unit_cnt <= unit_cnt + 16'h0001;
      if (next_state != state)
        unit_num <= 8'h00;
      else if (unit_tick && unit_num != 8'hFF)
        unit_num <= unit_num + 8'h01;
      if (state == ST_TRY && next_state == ST_TRY)
        try_cnt <= try_cnt + 16'h0001;
      else
        try_cnt <= 16'h0000;
      if (next_state == ST_TRY && state == ST_WAIT && attempts_used != 3'h7)
        attempts_used <= attempts_used + 3'h1;
      else if (next_state == ST_RUN && state != ST_RUN)
        attempts_used <= 3'h0;
      // sticky status, set wins over clear
      if (oc_detect)
        oc_status <= 1'b1;
      else if (fault_clear)
        oc_status <= 1'b0;
      host_alert_b <= !(oc_detect || (oc_status && !fault_clear));
      output_enable <= (next_state == ST_RUN) || (next_state == ST_LIMIT) ||
                       (next_state == ST_TRY);
      current_limit <= (next_state == ST_LIMIT);
      latched_off <= (next_state == ST_LATCH);
    end
  end

endmodule // ocf_core
`default_nettype wire

//--- test/ocf_plant.sv
`timescale 1ns/100ps
`default_nettype none
// load that draws fault current only while powered and shorted
module ocf_plant (
  input wire logic enable,
  input wire logic shorted,
  output wire logic overcurrent,
  output wire logic restarted
);
  assign overcurrent = enable & shorted;
  assign restarted = enable & !shorted;
endmodule // ocf_plant
`default_nettype wire

//--- test/ocf_core_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module ocf_core_assertions (
  input wire clk,
  input wire rst_b,
  input wire cfg_we,
  input wire oc_detect,
  input wire vout_below_floor,
  input wire output_on_cmd,
  input wire other_fault,
  input wire [7:0] cfg_rdata,
  input wire oc_status,
  input wire host_alert_b,
  input wire output_enable,
  input wire current_limit,
  input wire latched_off,
  input wire [2:0] attempts_used
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire run = output_enable && output_on_cmd && !other_fault && !cfg_we;
  wire [1:0] md = cfg_rdata[7:6];
  chk_status_set: assert property (oc_detect |=> oc_status)
    else $error("status bit not set");
  chk_alert_low: assert property (oc_detect |=> !host_alert_b)
    else $error("host not told");
  chk_ignore_run: assert property (md == 0 && oc_detect && run |=> output_enable)
    else $error("ignore mode shut down");
  chk_cond_trip: assert property (md == 1 && oc_detect && vout_below_floor && run
    |=> !output_enable)
    else $error("floor breach kept output");
  chk_off_now: assert property (md == 3 && oc_detect && run |=> !output_enable)
    else $error("no immediate shutdown");
  chk_latch_dark: assert property (latched_off |-> !output_enable)
    else $error("output on while latched");
  chk_cmd_off: assert property (!output_on_cmd |=> !output_enable)
    else $error("output ignores off command");
  chk_attempt_cap: assert property (cfg_rdata[5:3] != 7 |->
    attempts_used <= cfg_rdata[5:3])
    else $error("too many attempts");
  cover property (latched_off);
  cover property (current_limit && output_enable);
  cover property (attempts_used == 3'h6);
endmodule // ocf_core_assertions
bind ocf_core ocf_core_assertions u_chk (.*);
`default_nettype wire

//--- test/ocf_core_bench.sv
`timescale 1ns/100ps
`default_nettype none
module ocf_core_bench;
  logic clk = 0, rst_b = 0, cfg_we = 0, unit_we = 0, flr = 0, on = 1, oth = 0, clr = 0, sh = 0;
  logic [7:0] wd = 8'h00;
  wire oc, ok, oe, cl, lo, st, al;
  wire [7:0] rd;
  wire [15:0] ud;
  wire [2:0] at;
  int mismatches = 0, n_checks = 0, k, m, n;
  initial forever #4 clk = ~clk;
  ocf_core DUT (.clk(clk), .rst_b(rst_b), .cfg_we(cfg_we), .cfg_wdata(wd), .unit_we(unit_we),
    .unit_wdata(16'h0003), .oc_detect(oc), .vout_below_floor(flr), .output_on_cmd(on),
    .other_fault(oth), .fault_clear(clr), .restart_ok(ok), .cfg_rdata(rd), .unit_rdata(ud),
    .oc_status(st), .host_alert_b(al), .output_enable(oe), .current_limit(cl),
    .latched_off(lo), .attempts_used(at));
  ocf_plant plant (.enable(oe), .shorted(sh), .overcurrent(oc), .restarted(ok));
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (e !== g) begin
      mismatches++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task cy(input int c);
    repeat (c) @(posedge clk);
  endtask
  task wcfg(input logic [7:0] v);
    wd <= v;
    cfg_we <= 1;
    cy(1);
    cfg_we <= 0;
    cy(1);
  endtask
  task wlo;
    for (k = 0; k < 3000 && lo !== 1'b1; k++) cy(1);
    if (k == 3000) begin
      mismatches++;
      tally_and_finish;
    end
  endtask
  // off-on cycle plus clear releases the latch
  task rel(input string t);
    sh <= 0;
    on <= 0;
    cy(2);
    on <= 1;
    clr <= 1;
    cy(1);
    clr <= 0;
    cy(2);
    chk("latch", 8'h00, {7'h00, lo});
    chk("status", 8'h00, {7'h00, st});
    $display("test %s done", t);
  endtask
  initial begin
    cy(10);
    rst_b <= 1;
    cy(1);
    chk("cfg", 8'hC0, rd);
    chk("unit", 8'h01, ud[7:0]);
    unit_we <= 1;
    cy(1);
    unit_we <= 0;
    wcfg(8'hCA);
    sh <= 1;
    for (n = 0; n < 300 && oe; n++) cy(1);
    if (n == 300) mismatches++;
    for (n = 0; n < 300 && !oe; n++) cy(1);
    chk("gap", 8'd8, n[7:0]);
    wlo;
    chk("alert", 8'h00, {7'h00, al});
    rel("spacing");
    for (m = 0; m < 7; m++) begin
      wcfg({2'h3, m[2:0], 3'h0});
      sh <= 1;
      wlo;
      chk("tries", m[7:0], {5'h00, at});
    rel("count");
    end
    wcfg(8'hF8);
    sh <= 1;
    cy(200);
    chk("cont", 8'h00, {7'h00, lo});
    rel("continuous");
    wcfg(8'h00);
    sh <= 1;
    cy(50);
    chk("ign", 8'h03, {6'h00, oe, cl});
    rel("ignore");
    wcfg(8'h48);
    sh <= 1;
    cy(5);
    flr <= 1;
    cy(2);
    chk("floor", 8'h00, {7'h00, oe});
    flr <= 0;
    rel("floor");
    wcfg(8'h88);
    sh <= 1;
    wlo;
    chk("delay", 8'h01, {5'h00, at});
    rel("delay");
    tally_and_finish;
  end
endmodule // ocf_core_bench
`default_nettype wire
